//--- src/cff_params.svh
`ifndef CFF_PARAMS_SVH
`define CFF_PARAMS_SVH
`define CFF_NCH          4
`define CFF_CODE_NONE    2'h0
`define CFF_CODE_OPEN    2'h1
`define CFF_CODE_SGND    2'h2
`define CFF_CODE_SHORT   2'h3
`define CFF_CLK_MHZ      50
`define CFF_BLANK_US     10
`define CFF_FILTER_US    4
`define CFF_BLANK_CYC    (`CFF_BLANK_US * `CFF_CLK_MHZ)
`define CFF_FILTER_CYC   (`CFF_FILTER_US * `CFF_CLK_MHZ)
`define CFF_TMR_W        10
`define CFF_FRAME_BITS   16
`define CFF_BITCNT_W     5
`endif

//--- src/cff_pkg.sv
package cff_pkg;
  typedef logic [1:0] cff_code_t;
  typedef enum logic [1:0] {CFF_IDLE, CFF_BLANK, CFF_FILTER} cff_phase_e;
endpackage

//--- src/cff_top.sv
`timescale 1ns/1ps
`include "cff_params.svh"
// Overview of operation
// - Command off drives gate low and starts the blanking timer only; no filter timer runs.
// - Feedback below short-ground level at blanking end latches code 10 and flag.
// - Good-to-abnormal comparison change starts filter; status updates at filter end.
// - Latched code is frozen until a valid serial read of it completes or global enable falls.
// - Frame returns latched code; chip-select rise after a valid frame reloads latch from status.
// - A persistent fault keeps being returned by every following frame.
// - Abnormal-to-good change starts no filter; status shows no fault at once.
// - Reload with no-fault keeps the fault flag released.
// - Codes: 00 none, 01 open load, 10 short to ground, 11 shorted load.
// - Fault flag and codes hold after timers end, in latch-off recovery mode.
// - Fault flag released while global enable or chip select is low.
// - Latches re-arm after a valid frame or a global enable fall; invalid frames keep data.
// - Global enable high-low-high clears and re-arms latches and fault flag.
// - Diagnostics off when an enable is low, status flag only when global enable is low; latch only at timer end.
module cff_top (
  input  wire logic                    clk_sys,
  input  wire logic                    rst_n,
  input  wire logic                    spi_clk,
  input  wire logic                    chip_select_n,
  input  wire logic                    spi_mosi,
  output logic                         spi_miso,
  input  wire logic                    global_enable,
  input  wire logic                    output_stage_enable,
  input  wire logic [`CFF_NCH-1:0]     channel_cmd,
  input  wire logic [`CFF_NCH-1:0]     channel_mask,
  input  wire logic [`CFF_NCH-1:0]     below_short_ground,
  input  wire logic [`CFF_NCH-1:0]     below_open_load,
  input  wire logic [`CFF_NCH-1:0]     above_shorted_load,
  output logic [`CFF_NCH-1:0]          gate_drive_out,
  output logic                         fault_flag_n_out,
  output logic                         fault_flag_n_oe,
  output logic                         status_flag_n_out,
  output logic                         status_flag_n_oe,
  output logic [2*`CFF_NCH-1:0]        channel_fault_code
);
  // Pin synchronisers
  logic [`CFF_NCH-1:0] cmd_s1, cmd_s2, sg_s1, sg_s2, ol_s1, ol_s2, sl_s1, sl_s2;
  logic [`CFF_NCH-1:0] mask_s1, mask_s2;
  logic                en1_s1, en1_s2, en2_s1, en2_s2, cs_s1, cs_s2;
  logic                en1_d, en2_d, cs_d;
  always_ff @(posedge clk_sys) begin
    cmd_s1  <= channel_cmd;
    cmd_s2  <= cmd_s1;
    sg_s1   <= below_short_ground;
    sg_s2   <= sg_s1;
    ol_s1   <= below_open_load;
    ol_s2   <= ol_s1;
    sl_s1   <= above_shorted_load;
    sl_s2   <= sl_s1;
    mask_s1 <= channel_mask;
    mask_s2 <= mask_s1;
    en1_s1  <= global_enable;
    en1_s2  <= en1_s1;
    en2_s1  <= output_stage_enable;
    en2_s2  <= en2_s1;
    cs_s1   <= chip_select_n;
    cs_s2   <= cs_s1;
  end

  logic [`CFF_NCH-1:0] mask_r, cmd_r;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mask_r <= '0;
      cmd_r  <= '0;
      en1_d  <= 1'b0;
      en2_d  <= 1'b0;
      cs_d   <= 1'b1;
    end else begin
      mask_r <= mask_s2;
      cmd_r  <= cmd_s2;
      en1_d  <= en1_s2;
      en2_d  <= en2_s2;
      cs_d   <= cs_s2;
    end
  end

  logic diag_en, en_rise, cs_rise, cs_fall, en1_fall;
  assign diag_en  = en1_s2 & en2_s2;
  assign en_rise  = diag_en & ~(en1_d & en2_d);
  assign cs_rise  = cs_s2 & ~cs_d;
  assign cs_fall  = cs_d & ~cs_s2;
  assign en1_fall = en1_d & ~en1_s2;

  // Frame validity is a level that stays put between frames, so two flops suffice
  logic                       frame_valid_s;
  logic                       valid_link, vs1, vs2;
  logic [`CFF_FRAME_BITS-1:0] tx_word;
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vs1 <= 1'b0;
      vs2 <= 1'b0;
    end else begin
      vs1 <= valid_link;
      vs2 <= vs1;
    end
  end
  assign frame_valid_s = vs2;

  // Snapshot of the latched codes for the link; the host leaves at least three
  // clk_sys periods between chip select falling and its first clock edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n)
      tx_word <= '0;
    else if (cs_fall)
      tx_word <= {{(`CFF_FRAME_BITS-2*`CFF_NCH){1'b0}}, channel_fault_code};
  end

  function automatic cff_pkg::cff_code_t compare(input logic on, input logic sg,
                                                 input logic ol, input logic sl);
    cff_pkg::cff_code_t c;
    c = `CFF_CODE_NONE;
    if (on) begin
      if (sl)
        c = `CFF_CODE_SHORT;
    end else if (sg) begin
      c = `CFF_CODE_SGND;
    end else if (ol) begin
      c = `CFF_CODE_OPEN;
    end
    return c;
  endfunction

  logic [`CFF_NCH-1:0] latch_full, fault_live;
  genvar g;
  generate
    for (g = 0; g < `CFF_NCH; g++) begin : gen_ch
      cff_pkg::cff_phase_e  phase;
      logic [`CFF_TMR_W-1:0] tmr;
      cff_pkg::cff_code_t   cmp, cmp_d, status, held;
      logic                  gate_on;
      assign cmp = compare(gate_on, sg_s2[g], ol_s2[g], sl_s2[g]);
      assign fault_live[g] = (status != `CFF_CODE_NONE);

      // Gate: shorted load forces latch-off until commanded again
      always_ff @(posedge clk_sys) begin
        if (!rst_n || !diag_en)
          gate_on <= 1'b0;
        else if (en_rise || cmd_r[g] != cmd_s2[g])
          gate_on <= cmd_s2[g];
        else if (phase == cff_pkg::CFF_IDLE && status == `CFF_CODE_SHORT)
          gate_on <= 1'b0;
      end

      always_ff @(posedge clk_sys) begin
        if (!rst_n || !diag_en) begin
          phase  <= cff_pkg::CFF_IDLE;
          tmr    <= '0;
          status <= `CFF_CODE_NONE;
          cmp_d  <= `CFF_CODE_NONE;
        end else begin
          cmp_d <= cmp;
          case (phase)
            cff_pkg::CFF_IDLE: begin
              if (en_rise || cmd_r[g] != cmd_s2[g]) begin
                phase <= cff_pkg::CFF_BLANK;
                tmr   <= `CFF_TMR_W'(`CFF_BLANK_CYC - 1);
              end else if (cmp != cmp_d && cmp != `CFF_CODE_NONE) begin
                phase <= cff_pkg::CFF_FILTER;
                tmr   <= `CFF_TMR_W'(`CFF_FILTER_CYC - 1);
              end else if (cmp == `CFF_CODE_NONE) begin
                status <= `CFF_CODE_NONE;
              end
            end
            cff_pkg::CFF_BLANK, cff_pkg::CFF_FILTER: begin
              if (cmd_r[g] != cmd_s2[g]) begin
                phase <= cff_pkg::CFF_BLANK;
                tmr   <= `CFF_TMR_W'(`CFF_BLANK_CYC - 1);
              end else if (tmr == '0) begin
                phase  <= cff_pkg::CFF_IDLE;
                status <= cmp;
              end else begin
                tmr <= tmr - 1'b1;
              end
            end
            default: phase <= cff_pkg::CFF_IDLE;
          endcase
        end
      end

      logic timer_end, full;
      assign timer_end = phase != cff_pkg::CFF_IDLE && tmr == '0 &&
                         cmd_r[g] == cmd_s2[g];
      always_ff @(posedge clk_sys) begin
        if (!rst_n || en1_fall) begin
          held <= `CFF_CODE_NONE;
          full <= 1'b0;
        end else if (cs_rise && frame_valid_s) begin
          // A fault captured in the re-arm cycle wins over the reload
          if (timer_end && cmp != `CFF_CODE_NONE) begin
            held <= cmp;
            full <= 1'b1;
          end else begin
            held <= status;
            full <= fault_live[g];
          end
        end else if (!full && timer_end && cmp != `CFF_CODE_NONE) begin
          held <= cmp;
          full <= 1'b1;
        end
      end
      assign latch_full[g] = full;
      assign channel_fault_code[2*g +: 2] = held;
      assign gate_drive_out[g] = gate_on;
    end
  endgenerate

  // Flags: open drain, enable low while pulling the pin low
  logic flt_set, sta_set;
  always_ff @(posedge clk_sys) begin
    // Also held off in the reload cycle so a cleared latch never flashes the flag
    if (!rst_n || !en1_s2 || !cs_s2 || cs_rise)
      flt_set <= 1'b0;
    else
      flt_set <= |(latch_full & ~mask_r) & en2_s2;
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n || !en1_s2)
      sta_set <= 1'b0;
    else
      sta_set <= |(ol_s2 & ~mask_r);
  end
  assign fault_flag_n_out  = 1'b0;
  assign fault_flag_n_oe   = ~flt_set;
  assign status_flag_n_out = 1'b0;
  assign status_flag_n_oe  = ~sta_set;

  // Link domain: clock idles high, bits leave on falling edges, MSB first
  logic [`CFF_FRAME_BITS-1:0] shreg;
  logic [`CFF_BITCNT_W-1:0]   bitcnt;
  always_ff @(posedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      bitcnt <= '0;
    end else if (bitcnt != `CFF_BITCNT_W'(`CFF_FRAME_BITS + 1)) begin
      bitcnt <= bitcnt + 1'b1;
    end
  end
  // Set by the last clock of an exact-length frame, kept until the next frame clocks
  always_ff @(posedge spi_clk) begin
    valid_link <= (bitcnt == `CFF_BITCNT_W'(`CFF_FRAME_BITS - 1));
  end
  // tx_word is frozen for the whole frame; serial input follows it for chaining
  always_ff @(negedge spi_clk or posedge chip_select_n) begin
    if (chip_select_n) begin
      shreg    <= '0;
      spi_miso <= 1'b0;
    end else if (bitcnt == '0) begin
      spi_miso <= tx_word[`CFF_FRAME_BITS-1];
      shreg    <= {tx_word[`CFF_FRAME_BITS-2:0], spi_mosi};
    end else begin
      spi_miso <= shreg[`CFF_FRAME_BITS-1];
      shreg    <= {shreg[`CFF_FRAME_BITS-2:0], spi_mosi};
    end
  end
endmodule

//--- tb/cff_top_properties.sv
`timescale 1ns/1ps
module cff_props (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic       chip_select_n,
  input wire logic       global_enable,
  input wire logic       output_stage_enable,
  input wire logic [3:0] channel_cmd,
  input wire logic [3:0] gate_drive_out,
  input wire logic       fault_flag_n_oe,
  input wire logic [7:0] channel_fault_code
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_reset_state: assert property (disable iff (1'b0) !rst_n [*3] |->
    gate_drive_out == 4'h0 && fault_flag_n_oe && channel_fault_code == 8'h00)
    else $error("bad reset");
  a_frame_flag_off: assert property (!chip_select_n [*4] |-> fault_flag_n_oe)
    else $error("flag in frame");
  a_enable_clears: assert property (!global_enable [*4] |-> fault_flag_n_oe &&
    gate_drive_out == 4'h0 && channel_fault_code == 8'h00) else $error("enable low");
  a_stage_gates_off: assert property (!output_stage_enable [*4] |-> !gate_drive_out)
    else $error("gate on");
  a_latch_hold: assert property ((chip_select_n && global_enable) [*6] ##0
    channel_fault_code[1:0] != 2'h0 |=> $stable(channel_fault_code[1:0])) else $error("moved");
  a_flag_has_fault: assert property (!fault_flag_n_oe [*3] |-> channel_fault_code != 8'h00)
    else $error("flag no fault");
  a_cmd_off_gate: assert property ($fell(channel_cmd[0]) |-> ##[1:4] !gate_drive_out[0])
    else $error("gate stays on");
  a_ground_when_off: assert property ($rose(channel_fault_code[1:0] == 2'h2) |->
    !gate_drive_out[0]) else $error("ground fault while on");
  c_ground: cover property (channel_fault_code[1:0] == 2'h2);
  c_open: cover property (channel_fault_code[1:0] == 2'h1);
  c_frame: cover property ($rose(chip_select_n));
endmodule
bind cff_top cff_props chk (.clk_sys, .rst_n, .chip_select_n, .global_enable,
  .output_stage_enable, .channel_cmd, .gate_drive_out, .fault_flag_n_oe, .channel_fault_code);

//--- tb/cff_host.sv
`timescale 1ns/1ps
module cff_host (
  output logic      spi_clk,
  output logic      chip_select_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_clk = 1'b1;
    chip_select_n = 1'b1;
    spi_mosi = 1'b0;
  end
  // Link clock idles high and runs only inside a frame; data is taken on rising
  // edges, a full half period after the device moved it; mosi flips once released
  task automatic frame(input int n, output logic [15:0] rx);
    rx = 16'h0000;
    chip_select_n = 1'b0;
    #211;
    repeat (n) begin
      spi_mosi = 1'($urandom);
      #16 spi_clk = 1'b0;
      #16 spi_clk = 1'b1;
      rx = {rx[14:0], spi_miso};
    end
    #16 chip_select_n = 1'b1;
    spi_mosi = ~spi_mosi;
  endtask
endmodule

//--- tb/test_channel_fault_capture_flags.sv
`timescale 1ns/1ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
module test_channel_fault_capture_flags;
  logic       clk_sys, rst_n, spi_clk, chip_select_n, spi_mosi, spi_miso;
  logic       global_enable, output_stage_enable, fault_flag_n_out, fault_flag_n_oe;
  logic       status_flag_n_out, status_flag_n_oe;
  logic [3:0] channel_cmd, channel_mask, below_short_ground, below_open_load;
  logic [3:0] above_shorted_load, gate_drive_out;
  logic [7:0] channel_fault_code;
  int         n_errors, samples_checked, lat, st;
  cff_top uut (.*);
  cff_host host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  task automatic step(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wait_code(input logic [7:0] e, input int lim);
    int k;
    k = 0;
    while (channel_fault_code !== e && k < lim) begin
      step(1);
      k++;
    end
    `CHK(channel_fault_code, e)
    if (channel_fault_code !== e) tally_and_finish();
  endtask
  // Model: lat is the latched code, st the live status of channel 0
  task automatic rd(input int n);
    logic [15:0] r;
    host.frame(n, r);
    if (n == 16) begin
      `CHK(r, 16'(lat))
      lat = st;
    end
    step(8);
    `CHK(channel_fault_code, 8'(lat))
    `CHK(fault_flag_n_oe, lat == 0)
    `CHK(status_flag_n_oe, ~|(below_open_load & ~channel_mask))
    `CHK({fault_flag_n_out, status_flag_n_out}, 2'b00)
  endtask
  initial begin
    void'($urandom(32'h516bdcc8));
    {rst_n, global_enable, output_stage_enable, channel_cmd, above_shorted_load} = '0;
    {channel_mask, below_short_ground, below_open_load} = {3'($urandom), 9'h0FF};
    step(4);
    rst_n = 1'b1;
    {global_enable, output_stage_enable, channel_cmd} = 6'h3F;
    step(600);
    `CHK({gate_drive_out, channel_fault_code}, 12'hF00)
    $display("test 1 end");
    channel_cmd[0] = 1'b0;
    st = 2;
    step(4);
    `CHK(gate_drive_out[0], 1'b0)
    step(480);
    `CHK(channel_fault_code, 8'h00)
    wait_code(8'h02, 40);
    lat = 2;
    $display("test 2 end");
    below_short_ground[0] = 1'b0;
    st = 1;
    step(230);
    rd(15);
    rd(16);
    rd(16);
    rd(16);
    $display("test 3 end");
    below_open_load[0] = 1'b0;
    st = 0;
    step(20);
    rd(16);
    rd(16);
    $display("test 4 end");
    below_open_load[0] = 1'b1;
    wait_code(8'h01, 240);
    global_enable = 1'b0;
    step(6);
    `CHK({gate_drive_out, fault_flag_n_oe, channel_fault_code}, 13'h0100)
    global_enable = 1'b1;
    wait_code(8'h01, 560);
    `CHK(gate_drive_out, 4'hE)
    $display("test 5 end");
    output_stage_enable = 1'b0;
    step(6);
    `CHK({gate_drive_out, channel_fault_code}, 12'h001)
    $display("test 6 end");
    tally_and_finish();
  end
endmodule
